// file: verification/scp_host_model.sv
/*
 * Serial host model that drives the control port's pins.
 * Assumes the bench clock and a resolved shared data line.
 */
`timescale 1ns/1ps
module scp_host_model (
    input  wire logic clock_i,
    input  wire logic sdio_i,
    input  wire logic sdo_i,
    output logic      sclk_o,
    output logic      cs_n_o,
    output logic      sdio_o,
    output logic      io_reset_o
);
    import scp_pkg::*;
    logic keep_sel;
    initial begin
        keep_sel = 1'b0;
        sclk_o = 1'b0;
        cs_n_o = 1'b1;
        sdio_o = 1'b0;
        io_reset_o = 1'b0;
    end
    // =====================================================================
    // Frame driver
    // =====================================================================
    task automatic half();
        repeat (4) @(posedge clock_i);
    endtask : half
    task automatic xfer(input logic [7:0] ins, input logic [47:0] wd, input int nbits,
                        input logic lsb, input logic sep, input int pause_at,
                        input int abort_at, output logic [47:0] rd);
        int n;
        int k;
        rd = '0;
        n = 8 + nbits;
        half();
        cs_n_o <= 1'b0;
        half();
        for (int i = 0; i < n; i++) begin
            k = (i < 8) ? (lsb ? i : 7 - i) : (lsb ? i - 8 : n - 1 - i);
            if (i == pause_at) begin
                cs_n_o <= 1'b1;
                repeat (3) half();
                cs_n_o <= 1'b0;
                half();
            end
            if (i == abort_at) begin
                io_reset_o <= 1'b1;
                sclk_o <= 1'b0;
                half();
                io_reset_o <= 1'b0;
                cs_n_o <= 1'b1;
                half();
                return;
            end
            sclk_o <= 1'b0;
            if (i < 8) sdio_o <= ins[k];
            else if (!ins[7]) sdio_o <= wd[k];
            else sdio_o <= ~sdio_o;
            half();
            if (i >= 8 && ins[7]) rd[k] = sep ? sdo_i : sdio_i;
            sclk_o <= 1'b1;
            half();
        end
        sclk_o <= 1'b0;
        half();
        if (!keep_sel) cs_n_o <= 1'b1;
        sdio_o <= ~sdio_o;
    endtask : xfer
endmodule : scp_host_model

// file: verification/serial_control_port_tb_top.sv
/*
 * Self-checking bench for the serial control port.
 * Assumes the package, design files and host model are compiled first.
 */
`timescale 1ns/1ps
module serial_control_port_tb_top;
    import scp_pkg::*;
    logic    clock_i, nrst_i, cfg_ready, sep, sclk, cs_n, host_d, io_reset;
    logic    sdio_o, sdio_oe_o, sdo_o, sdo_oe_o, cfg_valid;
    scp_wr_t cfg;
    scp_wr_t got[$];
    int      fails, checks, hi_cnt;
    wire     sdio_w = (sdio_oe_o === 1'b1) ? sdio_o : host_d;
    wire     sdo_w  = (sdo_oe_o === 1'b1) ? sdo_o : ~host_d;
    scp_port u_dut (.clock_i(clock_i), .nrst_i(nrst_i), .sclk_i(sclk), .cs_n_i(cs_n),
        .sdio_i(sdio_w), .io_reset_i(io_reset), .sdio_o(sdio_o), .sdio_oe_o(sdio_oe_o),
        .sdo_o(sdo_o), .sdo_oe_o(sdo_oe_o), .cfg_valid_o(cfg_valid), .cfg_o(cfg),
        .cfg_ready_i(cfg_ready));
    scp_host_model u_host (.clock_i(clock_i), .sdio_i(sdio_w), .sdo_i(sdo_w),
        .sclk_o(sclk), .cs_n_o(cs_n), .sdio_o(host_d), .io_reset_o(io_reset));
    initial begin
        clock_i = 1'b0;
        forever #50 clock_i = ~clock_i;
    end
    // =====================================================================
    // Checking helpers
    // =====================================================================
    task automatic chk(input string name, input logic [55:0] exp, input logic [55:0] act);
        checks++;
        if (exp !== act) begin
            fails++;
            $display("unexpected %s: expected %h, seen %h", name, exp, act);
        end
    endtask : chk
    task automatic finish_test();
        if (fails == 0 && checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : finish_test
    always @(posedge clock_i) begin
        if (cfg_valid === 1'b1 && cfg_ready === 1'b1) got.push_back(cfg);
        hi_cnt <= (cs_n === 1'b1) ? hi_cnt + 1 : 0;
        if (hi_cnt > 3) chk("idle_oe", 56'h0, {sdio_oe_o, sdo_oe_o});
        if (!sep) chk("sdo_oe_shared", 56'h0, sdo_oe_o);
        else chk("sdio_oe_split", 56'h0, sdio_oe_o);
    end
    task automatic pop_cfg(input logic [4:0] a, input logic [47:0] d);
        int n;
        for (n = 0; n < 40 && got.size() == 0; n++) @(posedge clock_i);
        if (got.size() == 0) begin
            chk("cfg_timeout", 56'h1, 56'h0);
            finish_test();
        end
        chk("cfg_entry", {3'h0, a, d}, {3'h0, got.pop_front()});
    endtask : pop_cfg
    task automatic frame(input logic [7:0] ins, input logic [47:0] wd, input logic lsb,
                         input int pa, input int ab, output logic [47:0] rd);
        u_host.xfer(ins, wd, (ins[4:1] == 4'h0) ? 32 : 48, lsb, sep, pa, ab, rd);
    endtask : frame
    // =====================================================================
    // Scenarios
    // =====================================================================
    task automatic s_basic();
        logic [47:0] rd;
        frame(8'h64, 48'h9a5c_3e71_0f2d, 1'b0, -1, -1, rd);
        pop_cfg(5'h04, 48'h9a5c_3e71_0f2d);
        frame(8'h01, 48'h0000_c3a5_5a3c, 1'b0, -1, -1, rd);
        pop_cfg(5'h01, 48'h0000_c3a5_5a3c);
        u_host.keep_sel = 1'b1;
        frame(8'he4, 48'h0, 1'b0, -1, -1, rd);
        chk("read_tune", 56'h9a5c_3e71_0f2d, rd);
        frame(8'h81, 48'h0, 1'b0, -1, -1, rd);
        chk("read_ctl2", 56'h0000_c3a5_5a3c, rd);
        u_host.keep_sel = 1'b0;
    endtask : s_basic
    task automatic s_pause();
        logic [47:0] rd;
        frame(8'h05, 48'h1234_5678_9abc, 1'b0, 20, -1, rd);
        pop_cfg(5'h05, 48'h1234_5678_9abc);
        frame(8'h85, 48'h0, 1'b0, 30, -1, rd);
        chk("read_paused", 56'h1234_5678_9abc, rd);
    endtask : s_pause
    task automatic s_abort();
        logic [47:0] rd;
        frame(8'h05, 48'hffff_ffff_ffff, 1'b0, -1, 25, rd);
        frame(8'h06, 48'h0f0f_0f0f_0f0f, 1'b0, -1, -1, rd);
        pop_cfg(5'h06, 48'h0f0f_0f0f_0f0f);
        frame(8'h85, 48'h0, 1'b0, -1, -1, rd);
        chk("read_kept", 56'h1234_5678_9abc, rd);
    endtask : s_abort
    task automatic s_lsb();
        logic [47:0] rd;
        frame(8'h00, 48'h8000, 1'b0, -1, -1, rd);
        pop_cfg(5'h00, 48'h8000);
        frame(8'h07, 48'h00c0_ffee_1234, 1'b1, -1, -1, rd);
        pop_cfg(5'h07, 48'h00c0_ffee_1234);
        frame(8'h87, 48'h0, 1'b1, -1, -1, rd);
        chk("read_lsb", 56'h00c0_ffee_1234, rd);
        frame(8'h00, 48'h0, 1'b1, -1, -1, rd);
        pop_cfg(5'h00, 48'h0);
    endtask : s_lsb
    task automatic s_sep();
        logic [47:0] rd;
        frame(8'h00, 48'h80, 1'b0, -1, -1, rd);
        pop_cfg(5'h00, 48'h80);
        sep = 1'b1;
        frame(8'h84, 48'h0, 1'b0, -1, -1, rd);
        chk("read_sdo", 56'h9a5c_3e71_0f2d, rd);
        frame(8'h00, 48'h0, 1'b0, -1, -1, rd);
        pop_cfg(5'h00, 48'h0);
        sep = 1'b0;
    endtask : s_sep
    task automatic s_fifo();
        logic [47:0] rd;
        cfg_ready <= 1'b0;
        for (int i = 0; i < FIFO_DEPTH; i++)
            frame(8'h08 + 8'(i), 48'(i) * 48'h0101_0101_0101, 1'b0, -1, -1, rd);
        chk("stall_valid", 56'h1, cfg_valid);
        cfg_ready <= 1'b1;
        for (int i = 0; i < FIFO_DEPTH; i++)
            pop_cfg(5'h08 + 5'(i), 48'(i) * 48'h0101_0101_0101);
    endtask : s_fifo
    initial begin
        nrst_i = 1'b0;
        cfg_ready = 1'b1;
        sep = 1'b0;
        fails = 0;
        checks = 0;
        hi_cnt = 0;
        repeat (8) @(posedge clock_i);
        nrst_i <= 1'b1;
        repeat (4) @(posedge clock_i);
        s_basic();
        s_pause();
        s_abort();
        s_lsb();
        s_sep();
        s_fifo();
        finish_test();
    end
endmodule : serial_control_port_tb_top

// file: verilog/scp_fifo.sv
/*
 * Synchronous FIFO with valid/ready on both sides.
 * Assumes one clock and an already synchronised active-low reset.
 */
`timescale 1ns/1ps
module scp_fifo #(
    parameter int W     = 53,
    parameter int DEPTH = 16
) (
    input  wire logic         clock_i,
    input  wire logic         rst_n_i,
    input  wire logic         in_valid_i,
    output logic              in_ready_o,
    input  wire logic [W-1:0] in_data_i,
    output logic              out_valid_o,
    input  wire logic         out_ready_i,
    output logic [W-1:0]      out_data_o
);
    localparam int PW = $clog2(DEPTH);
    localparam int CW = $clog2(DEPTH + 1);

    typedef struct packed {
        logic [DEPTH-1:0][W-1:0] mem;
        logic [PW-1:0]           wr;
        logic [PW-1:0]           rd;
        logic [CW-1:0]           cnt;
    } scp_fifo_st_t;

    scp_fifo_st_t st_q;
    scp_fifo_st_t st_d;
    logic         push;
    logic         pop;

    assign in_ready_o  = (st_q.cnt != CW'(DEPTH));
    assign out_valid_o = (st_q.cnt != '0);
    assign out_data_o  = st_q.mem[st_q.rd];
    assign push        = in_valid_i & in_ready_o;
    assign pop         = out_valid_o & out_ready_i;

    always_comb begin
        st_d = st_q;
        if (push) begin
            st_d.mem[st_q.wr] = in_data_i;
            st_d.wr           = (st_q.wr == PW'(DEPTH - 1)) ? '0 : st_q.wr + 1'b1;
        end
        if (pop) begin
            st_d.rd = (st_q.rd == PW'(DEPTH - 1)) ? '0 : st_q.rd + 1'b1;
        end
        case ({push, pop})
            2'b10:   st_d.cnt = st_q.cnt + 1'b1;
            2'b01:   st_d.cnt = st_q.cnt - 1'b1;
            default: st_d.cnt = st_q.cnt;
        endcase
    end

    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

endmodule : scp_fifo

// file: verilog/scp_pkg.sv
/*
 * Shared constants and types for the serial control port.
 * Assumes nothing beyond a SystemVerilog compiler; no clocks live here.
 */
package scp_pkg;

    // =====================================================================
    // Frame layout
    // =====================================================================
    localparam int               INSTR_BITS    = 8;
    localparam int               RW_BIT        = 7;
    localparam int               ADDR_W        = 5;
    localparam int               DATA_W        = 48;
    localparam int               CNT_W         = 6;
    localparam logic [CNT_W-1:0] INSTR_LAST    = 6'h07;

    // =====================================================================
    // Register map and control fields
    // =====================================================================
    localparam logic [ADDR_W-1:0] CTL1_ADDR     = 5'h00;
    localparam logic [ADDR_W-1:0] CTL2_ADDR     = 5'h01;
    localparam logic [CNT_W-1:0]  CTL_BITS      = 6'h20;
    localparam logic [CNT_W-1:0]  TUNE_BITS     = 6'h30;
    localparam int                SEP_PINS_BIT  = 7;
    localparam int                LSB_FIRST_BIT = 15;
    localparam logic [DATA_W-1:0] REG_RESET     = 48'h0;
    localparam int                NUM_REGS      = 32;
    localparam int                FIFO_DEPTH    = 16;

    // =====================================================================
    // Types
    // =====================================================================
    typedef enum logic {
        PH_INSTR = 1'b0,
        PH_DATA  = 1'b1
    } scp_phase_t;

    typedef struct packed {
        logic sclk;
        logic cs_n;
        logic sdio;
        logic io_reset;
    } scp_pins_t;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] data;
    } scp_wr_t;

    // Width in bits of the register at an address
    function automatic logic [CNT_W-1:0] scp_reg_bits(input logic [ADDR_W-1:0] a);
        return (a == CTL1_ADDR || a == CTL2_ADDR) ? CTL_BITS : TUNE_BITS;
    endfunction : scp_reg_bits

endpackage : scp_pkg

// file: verilog/scp_port.sv
/*
 * Serial control port: oversamples the host's serial clock, shifts
 * instruction and data, answers reads, and forwards writes through a FIFO.
 * Assumes clock_i at 10 MHz and a serial clock slow enough that each level
 * lasts at least two clock_i periods.
 */
// Operation
// - A cycle opens with an eight-bit instruction, then the data phase.
// - Data phase length equals the addressed register's width in bits.
// - After the last data bit, the next eight rising edges are an instruction.
// - Instruction and write bits are sampled on the serial clock's rising edge.
// - Read bits are launched on the serial clock's falling edge.
// - Instruction bit 7 high means read, low means write.
// - Instruction bits 6 and 5 are ignored.
// - Instruction bits 4 to 0 address the register.
// - Deselected port leaves both data pins undriven.
// - Deselect mid-cycle freezes progress; reselect resumes at the same point.
// - Write data always comes from the shared data pin.
// - First control word bit 7 picks shared or separate data pins.
// - In shared-pin mode the separate output stays undriven.
// - Port reset aborts the cycle, keeps registers, restarts with instruction.
// - First control word bit 15 picks MSB-first or LSB-first order.
// - All data bits travel in the selected bit order.
`timescale 1ns/1ps
module scp_port (
    input  wire logic    clock_i,
    input  wire logic    nrst_i,
    input  wire logic    sclk_i,
    input  wire logic    cs_n_i,
    input  wire logic    sdio_i,
    input  wire logic    io_reset_i,
    output logic         sdio_o,
    output logic         sdio_oe_o,
    output logic         sdo_o,
    output logic         sdo_oe_o,
    output logic         cfg_valid_o,
    output scp_pkg::scp_wr_t cfg_o,
    input  wire logic    cfg_ready_i
);
    import scp_pkg::*;

    // =====================================================================
    // State
    // =====================================================================
    typedef struct packed {
        scp_pins_t                           s1;
        scp_pins_t                           s2;
        scp_pins_t                           s3;
        scp_phase_t                          phase;
        logic [CNT_W-1:0]                    cnt;
        logic                                rw;
        logic [ADDR_W-1:0]                   addr;
        logic [DATA_W-1:0]                   shift;
        logic                                drive;
        logic                                dout;
        logic                                sdio_oe;
        logic                                sdo_oe;
        logic                                pend;
        scp_wr_t                             pend_w;
        logic                                cfg_v;
        scp_wr_t                             cfg;
        logic [NUM_REGS-1:0][DATA_W-1:0]     regs;
    } scp_state_t;

    scp_state_t        st_q;
    scp_state_t        st_d;
    logic [1:0]        rst_sync_q;
    logic              rst_n;
    logic              rise;
    logic              fall;
    logic              active;
    logic              lsb_first;
    logic              sep_pins;
    logic [CNT_W-1:0]  nbits;
    logic [CNT_W-1:0]  idx;
    logic              last;
    logic [DATA_W-1:0] nxt;
    logic              wr_done;
    logic              fifo_in_ready;
    logic              fifo_out_valid;
    logic              fifo_out_ready;
    scp_wr_t           fifo_out;

    // =====================================================================
    // Reset release
    // =====================================================================
    always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            rst_sync_q <= 2'h0;
        end else begin
            rst_sync_q <= {rst_sync_q[0], 1'b1};
        end
    end

    assign rst_n = rst_sync_q[1];

    // =====================================================================
    // Pin edges and decode
    // =====================================================================
    assign rise      = st_q.s2.sclk & ~st_q.s3.sclk;
    assign fall      = ~st_q.s2.sclk & st_q.s3.sclk;
    assign active    = ~st_q.s2.cs_n & ~st_q.s2.io_reset;
    assign lsb_first = st_q.regs[CTL1_ADDR][LSB_FIRST_BIT];
    assign sep_pins  = st_q.regs[CTL1_ADDR][SEP_PINS_BIT];
    assign nbits     = (st_q.phase == PH_INSTR) ? CNT_W'(INSTR_BITS)
                                                : scp_reg_bits(st_q.addr);
    // Bit position of the current serial bit
    assign idx       = lsb_first ? st_q.cnt : nbits - 1'b1 - st_q.cnt;
    assign last      = (st_q.cnt == nbits - 1'b1);

    always_comb begin
        nxt      = st_q.shift;
        nxt[idx] = st_q.s2.sdio;
    end

    // =====================================================================
    // Write forwarding buffer
    // =====================================================================
    assign fifo_out_ready = ~st_q.cfg_v | cfg_ready_i;

    scp_fifo #(
        .W     (ADDR_W + DATA_W),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .clock_i     (clock_i),
        .rst_n_i     (rst_n),
        .in_valid_i  (st_q.pend),
        .in_ready_o  (fifo_in_ready),
        .in_data_i   (st_q.pend_w),
        .out_valid_o (fifo_out_valid),
        .out_ready_i (fifo_out_ready),
        .out_data_o  (fifo_out)
    );

    // =====================================================================
    // Next state
    // =====================================================================
    always_comb begin
        st_d    = st_q;
        wr_done = 1'b0;
        st_d.s1 = '{sclk: sclk_i, cs_n: cs_n_i, sdio: sdio_i, io_reset: io_reset_i};
        st_d.s2 = st_q.s1;
        st_d.s3 = st_q.s2;

        if (st_q.s2.io_reset) begin
            // Abort, registers untouched
            st_d.phase = PH_INSTR;
            st_d.cnt   = '0;
            st_d.drive = 1'b0;
        end else if (active && rise) begin
            if (!(st_q.phase == PH_DATA && st_q.rw)) begin
                st_d.shift = nxt;
            end
            if (!last) begin
                st_d.cnt = st_q.cnt + 1'b1;
            end else if (st_q.phase == PH_INSTR) begin
                st_d.phase = PH_DATA;
                st_d.cnt   = '0;
                st_d.rw    = nxt[RW_BIT];
                // Bits 6 and 5 are dropped here
                st_d.addr  = nxt[ADDR_W-1:0];
                st_d.shift = st_q.regs[nxt[ADDR_W-1:0]];
            end else begin
                st_d.phase = PH_INSTR;
                st_d.cnt   = '0;
                st_d.drive = 1'b0;
                if (!st_q.rw) begin
                    st_d.pend   = 1'b1;
                    wr_done     = 1'b1;
                    st_d.pend_w = '{addr: st_q.addr, data: nxt};
                end
            end
        end else if (active && fall && st_q.phase == PH_DATA && st_q.rw) begin
            st_d.drive = 1'b1;
            st_d.dout  = st_q.shift[idx];
        end

        // Push of a completed write; a new completion wins over the clear
        if (st_q.pend && fifo_in_ready && !wr_done) begin
            st_d.pend = 1'b0;
        end

        st_d.sdio_oe = st_d.drive & ~sep_pins & ~st_q.s2.cs_n;
        st_d.sdo_oe  = st_d.drive & sep_pins & ~st_q.s2.cs_n;

        if (fifo_out_ready) begin
            st_d.cfg_v = fifo_out_valid;
            if (fifo_out_valid) begin
                st_d.cfg                      = fifo_out;
                st_d.regs[fifo_out.addr]      = fifo_out.data;
            end
        end
    end

    always_ff @(posedge clock_i or negedge rst_n) begin
        if (!rst_n) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    // =====================================================================
    // Checks on pin drive
    // =====================================================================
    // Deselect releases both pins
    a_idle_no_drive: assert property (
        @(posedge clock_i) disable iff (!rst_n)
        st_q.s2.cs_n
        |=> !sdio_oe_o && !sdo_oe_o
    ) else $error("data pin driven while deselected");

    // Shared mode keeps the output pin off
    a_shared_sdo_off: assert property (
        @(posedge clock_i) disable iff (!rst_n)
        !sep_pins
        |=> !sdo_oe_o
    ) else $error("separate output driven in shared mode");

    // Split mode never drives the shared pin
    a_split_sdio_off: assert property (
        @(posedge clock_i) disable iff (!rst_n)
        sep_pins
        |=> !sdio_oe_o
    ) else $error("shared pin driven in split mode");

    // Drive only in a read data phase
    a_oe_only_read: assert property (
        @(posedge clock_i) disable iff (!rst_n)
        sdio_oe_o || sdo_oe_o
        |-> st_q.phase == PH_DATA && st_q.rw
    ) else $error("data pin driven outside a read");

    // =====================================================================
    // Checks on serial edges
    // =====================================================================
    // Bit count moves only on a rise or a port reset
    a_count_on_rise: assert property (
        @(posedge clock_i) disable iff (!rst_n)
        !(active && rise) && !st_q.s2.io_reset
        |=> $stable(st_q.cnt)
    ) else $error("bit count moved without a serial rise");

    // Read bit changes only on a fall
    a_dout_on_fall: assert property (
        @(posedge clock_i) disable iff (!rst_n)
        !(active && fall)
        |=> $stable(sdio_o)
    ) else $error("read bit changed without a serial fall");

    // Deselect freezes the cycle
    a_freeze_deselect: assert property (
        @(posedge clock_i) disable iff (!rst_n)
        st_q.s2.cs_n && !st_q.s2.io_reset
        |=> $stable(st_q.phase) && $stable(st_q.cnt) && $stable(st_q.addr)
    ) else $error("cycle progressed while deselected");

    // Read word kept intact while shifted out
    a_read_word_hold: assert property (
        @(posedge clock_i) disable iff (!rst_n)
        st_q.phase == PH_DATA && st_q.rw
        |=> $stable(st_q.shift)
    ) else $error("read word altered during read");

    // =====================================================================
    // Checks on framing
    // =====================================================================
    // Instruction is eight bits
    a_instr_len: assert property (
        @(posedge clock_i) disable iff (!rst_n)
        st_q.phase == PH_INSTR
        |-> st_q.cnt < CNT_W'(INSTR_BITS)
    ) else $error("instruction count out of range");

    // Data phase bounded by register width
    a_data_len: assert property (
        @(posedge clock_i) disable iff (!rst_n)
        st_q.phase == PH_DATA
        |-> st_q.cnt < scp_reg_bits(st_q.addr)
    ) else $error("data count beyond register width");

    // Eighth rise opens the data phase
    a_instr_to_data: assert property (
        @(posedge clock_i) disable iff (!rst_n)
        active && rise && last && st_q.phase == PH_INSTR
        |=> st_q.phase == PH_DATA && st_q.cnt == '0
    ) else $error("data phase did not follow instruction");

    // Last data bit returns to instruction
    a_data_to_instr: assert property (
        @(posedge clock_i) disable iff (!rst_n)
        active && rise && last && st_q.phase == PH_DATA
        |=> st_q.phase == PH_INSTR && st_q.cnt == '0 && !st_q.drive
    ) else $error("new instruction did not follow data");

    // Port reset restarts at the instruction
    a_abort_clears: assert property (
        @(posedge clock_i) disable iff (!rst_n)
        st_q.s2.io_reset
        |=> st_q.phase == PH_INSTR && st_q.cnt == '0 && !st_q.drive
    ) else $error("port reset did not abort the cycle");

    // Aborted cycle never queues a write
    a_abort_no_write: assert property (
        @(posedge clock_i) disable iff (!rst_n)
        st_q.s2.io_reset
        |-> !wr_done
    ) else $error("write queued during port reset");

    // First read bit on the first data fall
    a_first_read_bit: assert property (
        @(posedge clock_i) disable iff (!rst_n)
        $rose(st_q.drive)
        |-> st_q.cnt == '0 && $past(fall)
    ) else $error("read drive started at the wrong bit");

    // Reads never queue a write
    a_read_no_push: assert property (
        @(posedge clock_i) disable iff (!rst_n)
        st_q.phase == PH_DATA && st_q.rw
        |-> !wr_done
    ) else $error("read cycle queued a write");

    // Completed write is queued
    a_write_queued: assert property (
        @(posedge clock_i) disable iff (!rst_n)
        wr_done
        |=> st_q.pend
    ) else $error("completed write not queued");

    // Stalled write output holds
    a_cfg_hold: assert property (
        @(posedge clock_i) disable iff (!rst_n)
        cfg_valid_o && !cfg_ready_i
        |=> cfg_valid_o && $stable(cfg_o)
    ) else $error("stalled write output changed");

    assign sdio_o      = st_q.dout;
    assign sdo_o       = st_q.dout;
    assign sdio_oe_o   = st_q.sdio_oe;
    assign sdo_oe_o    = st_q.sdo_oe;
    assign cfg_valid_o = st_q.cfg_v;
    assign cfg_o       = st_q.cfg;

endmodule : scp_port
